// ---- rps_pkg.sv ----
// Purpose: Shared constants and types for the receive port status register block
// Assumes: Byte-wide register reads arrive from the device's own serial-control front end
// Notes: Offsets are register addresses on the control bus
package rps_pkg;
    localparam logic [7:0] RPS_PORT_SEL_ADDR = 8'h4c;
    localparam logic [7:0] RPS_STATUS_ONE_ADDR = 8'h4d;
    localparam logic [7:0] RPS_STATUS_ONE_RESET = 8'h00;
    localparam int RPS_PORT_NUM_MSB = 7;
    localparam int RPS_PORT_NUM_LSB = 6;
    localparam int RPS_CRC_ERR_BIT = 5;
    localparam int RPS_LOCK_CHG_BIT = 4;
    localparam int RPS_SEQ_ERR_BIT = 3;
    localparam int RPS_PARITY_BIT = 2;
    localparam int RPS_ACCEPT_BIT = 1;
    localparam int RPS_LOCKED_BIT = 0;
    localparam int RPS_READ_PORT_LSB = 4;
    localparam int RPS_NUM_PORTS = 4;

    // Per-port live status and event inputs
    typedef struct packed {
        logic crc_err_evt;
        logic seq_err_evt;
        logic chan_err_flag;
        logic parity_over_limit;
        logic link_accept_flag;
        logic receiver_locked;
    } rps_port_in_t;

    // Register bus request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rps_bus_req_t;
endpackage

// ---- rps_status_one.sv ----
// Purpose: Paged receiver_port_status_one register for four receive ports
// Assumes: Read strobes and status inputs are synchronous to CORE_CLK_IN
// Notes: Read data is registered; clear-on-read acts on the page selected at the read
//
// Notes on behaviour
// - Each receive port keeps its own status copy and reads return the one chosen at 0x4C.
// - Read-port select values 0..3 pick receive ports 0..3 for readback.
// - Bits 7:6 return the index of the port chosen for readback.
// - Bit 5 is set by a control-channel CRC error and cleared by reading the register.
// - Bit 4 is set when the lock state changes and cleared by reading the register.
// - With enhanced errors off, bit 3 is a sticky sequence error cleared by this read.
// - With enhanced errors on, bit 3 is the channel error flag cleared only elsewhere.
// - Bit 2 is high while the parity error count exceeds the programmed limit.
// - The parity flag is not cleared by reading this register.
// - Bit 1 follows the live link accept flag.
// - Bit 0 follows the live receiver lock state.
`timescale 1ns/1ps
`default_nettype none
module rps_status_one
    import rps_pkg::*;
#(
    parameter int NPORT = RPS_NUM_PORTS
) (
    input wire logic CORE_CLK_IN,
    input wire logic SRST_IN,
    input wire rps_bus_req_t BUS_REQ_IN,
    input wire rps_port_in_t [NPORT-1:0] PORT_STAT_IN,
    input wire logic ENH_ERR_ENABLE_IN,
    output logic [7:0] RDATA_OUT,
    output logic RVALID_OUT,
    output logic [1:0] READ_PORT_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode shared by the select register and status register paths
    function automatic logic hit(input rps_bus_req_t r, input logic [7:0] a);
        hit = (r.addr == a);
    endfunction

    logic [1:0] sel_q, sel_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic rd_status;
    logic [NPORT-1:0] crc_q, crc_d, chg_q, chg_d, seq_q, seq_d, lock_prev_q, lock_prev_d;

    assign rd_status = BUS_REQ_IN.rd && hit(BUS_REQ_IN, RPS_STATUS_ONE_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // Read port select; loaded from bits 5:4 of a write to 0x4C
    always_comb begin
        sel_d = sel_q;
        if (BUS_REQ_IN.wr && hit(BUS_REQ_IN, RPS_PORT_SEL_ADDR)) begin
            sel_d = BUS_REQ_IN.wdata[RPS_READ_PORT_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags per port; a set in the clearing cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi++) begin : g_port
            logic clr;
            logic lock_evt;
            // Only the page selected at the read edge is cleared
            assign clr = rd_status && (sel_q == 2'(gi));
            // Compare with the previous sample; the history resets to unlocked
            assign lock_evt = PORT_STAT_IN[gi].receiver_locked != lock_prev_q[gi];
            // Each port drives only its own bit, so no two processes share a vector
            assign crc_d[gi] = PORT_STAT_IN[gi].crc_err_evt | (crc_q[gi] & ~clr);
            assign chg_d[gi] = lock_evt | (chg_q[gi] & ~clr);
            // Sequence flag still collects in enhanced mode, shown only in normal mode
            assign seq_d[gi] = PORT_STAT_IN[gi].seq_err_evt | (seq_q[gi] & ~clr);
            assign lock_prev_d[gi] = PORT_STAT_IN[gi].receiver_locked;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Readback assembly from the selected page
    always_comb begin
        rps_port_in_t p;
        p = PORT_STAT_IN[sel_q];
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        if (rd_status) begin
            rvalid_d = 1'b1;
            rdata_d[RPS_PORT_NUM_MSB:RPS_PORT_NUM_LSB] = sel_q;
            rdata_d[RPS_CRC_ERR_BIT] = crc_q[sel_q];
            rdata_d[RPS_LOCK_CHG_BIT] = chg_q[sel_q];
            // Enhanced mode shows the flag owned by the channel status logic
            rdata_d[RPS_SEQ_ERR_BIT] = ENH_ERR_ENABLE_IN ? p.chan_err_flag
                                                         : seq_q[sel_q];
            rdata_d[RPS_PARITY_BIT] = p.parity_over_limit;
            rdata_d[RPS_ACCEPT_BIT] = p.link_accept_flag;
            rdata_d[RPS_LOCKED_BIT] = p.receiver_locked;
        end else if (BUS_REQ_IN.rd && hit(BUS_REQ_IN, RPS_PORT_SEL_ADDR)) begin
            rvalid_d = 1'b1;
            rdata_d = {2'b00, sel_q, 4'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge CORE_CLK_IN) begin
        if (SRST_IN) begin
            sel_q <= 2'h0;
            rdata_q <= RPS_STATUS_ONE_RESET;
            rvalid_q <= 1'b0;
            crc_q <= '0;
            chg_q <= '0;
            seq_q <= '0;
            lock_prev_q <= '0;
        end else begin
            sel_q <= sel_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            crc_q <= crc_d;
            chg_q <= chg_d;
            seq_q <= seq_d;
            lock_prev_q <= lock_prev_d;
        end
    end

    assign RDATA_OUT = rdata_q;
    assign RVALID_OUT = rvalid_q;
    assign READ_PORT_OUT = sel_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_port_num_field: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status |=> RDATA_OUT[7:6] == $past(sel_q))
        else $error("port number field wrong");
    a_sel_decode: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        BUS_REQ_IN.wr && BUS_REQ_IN.addr == RPS_PORT_SEL_ADDR
        |=> sel_q == $past(BUS_REQ_IN.wdata[5:4]))
        else $error("read port select not taken");
    a_crc_set: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        PORT_STAT_IN[0].crc_err_evt |=> crc_q[0])
        else $error("crc flag not set");
    a_crc_clear: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status && sel_q == 2'h0 && !PORT_STAT_IN[0].crc_err_evt |=> !crc_q[0])
        else $error("crc flag not cleared by read");
    a_lock_chg: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        $changed(PORT_STAT_IN[0].receiver_locked) ##1 1'b1 |-> chg_q[0])
        else $error("lock change not flagged");
    a_seq_clear: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status && sel_q == 2'h1 && !PORT_STAT_IN[1].seq_err_evt |=> !seq_q[1])
        else $error("sequence flag not cleared");
    a_enh_bit: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status && ENH_ERR_ENABLE_IN
        |=> RDATA_OUT[3] == $past(PORT_STAT_IN[sel_q].chan_err_flag))
        else $error("enhanced error bit wrong");
    a_parity_bit: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status |=> RDATA_OUT[2] == $past(PORT_STAT_IN[sel_q].parity_over_limit))
        else $error("parity bit wrong");
    a_live_bits: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status |=> RDATA_OUT[1:0] == {$past(PORT_STAT_IN[sel_q].link_accept_flag),
                                         $past(PORT_STAT_IN[sel_q].receiver_locked)})
        else $error("live bits wrong");
    a_set_wins: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status && PORT_STAT_IN[sel_q].seq_err_evt |=> seq_q[$past(sel_q)])
        else $error("event lost on clearing read");

    ////////////////////////////////////////////////////////////////////////////
    // Answer timing; the host takes read data on a fixed one-cycle answer
    a_rvalid_read: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status |=> RVALID_OUT)
        else $error("status read not answered");
    a_rvalid_idle: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        !BUS_REQ_IN.rd |=> !RVALID_OUT)
        else $error("read valid without a read");
    // Addresses outside this block must stay silent for the other register logic
    a_rvalid_unmapped: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        BUS_REQ_IN.rd && !hit(BUS_REQ_IN, RPS_PORT_SEL_ADDR)
        && !hit(BUS_REQ_IN, RPS_STATUS_ONE_ADDR) |=> !RVALID_OUT)
        else $error("unmapped read answered");

    // A read of one page must leave the other pages' flags alone
    a_other_page: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status && sel_q != 2'h0 && crc_q[0] |=> crc_q[0])
        else $error("read cleared another page");

    // The select only moves on a write to the select register
    a_sel_hold: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        !(BUS_REQ_IN.wr && BUS_REQ_IN.addr == RPS_PORT_SEL_ADDR) |=> $stable(sel_q))
        else $error("read port select moved without a write");

    ////////////////////////////////////////////////////////////////////////////
    // Sticky bits as returned to the host, and their clearing
    a_crc_bit: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status |=> RDATA_OUT[5] == $past(crc_q[sel_q]))
        else $error("crc bit wrong");
    a_crc_wins: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status && PORT_STAT_IN[sel_q].crc_err_evt |=> crc_q[$past(sel_q)])
        else $error("crc event lost on clearing read");
    a_lock_bit: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status |=> RDATA_OUT[4] == $past(chg_q[sel_q]))
        else $error("lock change bit wrong");
    // A read with no new lock event must clear the change flag of its page
    a_lock_clear: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status && sel_q == 2'h0
        && PORT_STAT_IN[0].receiver_locked == lock_prev_q[0] |=> !chg_q[0])
        else $error("lock change not cleared by read");
    // Without a read the change flag must stay until the host has seen it
    a_lock_hold: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        !rd_status && chg_q[0] |=> chg_q[0])
        else $error("lock change lost without a read");
    a_seq_set: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        PORT_STAT_IN[1].seq_err_evt |=> seq_q[1])
        else $error("sequence flag not set");
    a_seq_bit: assert property (@(posedge CORE_CLK_IN) disable iff (SRST_IN)
        rd_status && !ENH_ERR_ENABLE_IN |=> RDATA_OUT[3] == $past(seq_q[sel_q]))
        else $error("sequence bit wrong");

endmodule
`default_nettype wire

// ---- rps_host.sv ----
// Purpose: Host model that issues register reads and writes to the status block
// Assumes: Single-byte requests, rd or wr pulsed for one clock cycle
// Notes: Read data is taken just after the edge that accepts the request, while valid stands
`timescale 1ns/1ps
`default_nettype none
module rps_host
    import rps_pkg::*;
(
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    output rps_bus_req_t req_out
);
    logic [7:0] rd_q;
    logic seen_q;
    initial req_out = '0;
    // Launch 1 ns after an edge; valid stands only in the cycle after the taking edge
    // An idle cycle follows so that two calls never touch the request in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        req_out = '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk_in);
        #1;
        req_out = '0;
        seen_q = rvalid_in;
        rd_q = rdata_in;
        @(posedge clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the paged receiver port status register
// Assumes: Inputs change 1 ns after the rising clock edge
// Notes: Rows cover every bit; odd cases follow the loop
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rps_pkg::*;
    logic clk, srst, enh;
    rps_bus_req_t req;
    rps_port_in_t [3:0] ps;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] rport;
    logic [16:0] r;
    int error_cnt, checked, cyc;
    // Row: select, enhanced mode, port inputs, expected status byte
    logic [16:0] rows [5] = '{17'h03139, 17'h0de4e, 17'h10595, 17'h1e2e2, 17'h09048};
    rps_status_one u_rps_status_one (.CORE_CLK_IN(clk), .SRST_IN(srst), .BUS_REQ_IN(req),
        .PORT_STAT_IN(ps), .ENH_ERR_ENABLE_IN(enh), .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
        .READ_PORT_OUT(rport));
    rps_host u_rps_host (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Clock and hang guard; the whole run needs well under a thousand cycles
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        enh = 1'b0;
        ps = '0;
        repeat (12) @(posedge clk);
        #1 srst = 1'b0;
        tick(1);
        // Events pulse one cycle; levels stay; each row reads its selected page twice
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            u_rps_host.xfer(1'b1, RPS_PORT_SEL_ADDR, {2'h0, r[16:15], 4'h0});
            enh = r[14];
            ps[r[16:15]] = r[13:8];
            tick(1);
            ps[r[16:15]] = r[13:8] & 6'h0f;
            tick(2);
            chk("read port", {6'h0, r[16:15]}, {6'h0, rport});
            u_rps_host.xfer(1'b0, RPS_STATUS_ONE_ADDR, 8'h00);
            chk("status valid", 8'h01, {7'h0, u_rps_host.seen_q});
            chk("status", r[7:0], u_rps_host.rd_q);
            u_rps_host.xfer(1'b0, RPS_STATUS_ONE_ADDR, 8'h00);
            chk("reread", r[7:0] & (r[14] ? 8'hcf : 8'hc7), u_rps_host.rd_q);
        end
        // Error event in the very cycle of the clearing read must survive
        ps[1].crc_err_evt = 1'b1;
        ps[1].seq_err_evt = 1'b1;
        fork
            #10 ps[1] = '0;
        join_none
        u_rps_host.xfer(1'b0, RPS_STATUS_ONE_ADDR, 8'h00);
        u_rps_host.xfer(1'b0, RPS_STATUS_ONE_ADDR, 8'h00);
        chk("coincident", 8'h68, u_rps_host.rd_q);
        // Unmapped read gets no answer; a write to the status is ignored
        u_rps_host.xfer(1'b0, 8'h4e, 8'h00);
        chk("unmapped valid", 8'h00, {7'h0, u_rps_host.seen_q});
        u_rps_host.xfer(1'b1, RPS_STATUS_ONE_ADDR, 8'hff);
        u_rps_host.xfer(1'b0, RPS_PORT_SEL_ADDR, 8'h00);
        chk("select readback", 8'h10, u_rps_host.rd_q);
        u_rps_host.xfer(1'b0, RPS_STATUS_ONE_ADDR, 8'h00);
        chk("status after write", 8'h40, u_rps_host.rd_q);
        // A port 0 flag survives a read of port 1 and is then cleared by reset
        ps[0].crc_err_evt = 1'b1;
        tick(1);
        ps[0].crc_err_evt = 1'b0;
        u_rps_host.xfer(1'b0, RPS_STATUS_ONE_ADDR, 8'h00);
        chk("other page", 8'h40, u_rps_host.rd_q);
        // Mid-run reset returns select and status to their defaults
        ps = '0;
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        tick(1);
        chk("reset port", 8'h00, {6'h0, rport});
        u_rps_host.xfer(1'b0, RPS_STATUS_ONE_ADDR, 8'h00);
        chk("reset status", RPS_STATUS_ONE_RESET, u_rps_host.rd_q);
        end_of_test();
    end
endmodule
`default_nettype wire
